// ---- logic/clock_select_regs.vh ----
// Constants for the clock source select and multiplier control block.
// Assumes fuse pins read 1 when unprogrammed, oscillator ticks as pins.
//
// Notes on behaviour
// - Multiplier runs at 8x its source; low-speed select halves source.
// - Low-speed select cannot be set while multiplier feeds system clock.
// - Multiplier runs if enabled, or fuse code 0001, or 0011.
// - Lock flag set once the multiplier reports lock.
// - RC oscillator and multiplier off in power-down and standby.
// - Code 0011 is legacy mode: RC at 6.4 MHz, multiplier 4x.
// - Low-speed select has no effect in legacy mode.
// - Fuse code decodes to external, multiplier, RC, 128k, crystal, reserved.
// - Fuse bit one is unprogrammed, zero is programmed.
// - Legacy mode divides the system clock by four.
// - Wake from power-down waits on source cycles before execution.
// - Reset delay adds 512 or 8192 watchdog oscillator cycles.
// - External clock: 6 cycles wake; reset 14, 14+4ms, 14+64ms.
// - Multiplier as system clock is divided by four.
// - Multiplier source wake: 14 plus 1K/16K cycles plus 4/64 ms.
// - Some external interrupts detected while I/O clock halted.
// - Converter clock keeps running while core and I/O halted in noise-reduction sleep.
// - Program-memory clock gated together with the core clock.
// - Sleep modes stop unused clocks; core halt stops execution.
`ifndef CLOCK_SELECT_REGS_VH
`define CLOCK_SELECT_REGS_VH
// Register byte offsets
`define REG_CTRL_OFS     8'h00
`define REG_STATUS_OFS   8'h04
`define REG_TRIM_OFS     8'h08
// Control register fields
`define CTRL_LOCK_BIT    0
`define CTRL_ENABLE_BIT  1
`define CTRL_LSS_BIT     2
// Status register fields
`define STAT_SRC_LSB     0
`define STAT_LEGACY_BIT  3
`define STAT_RUN_BIT     4
`define STAT_MULT_BIT    5
`define STAT_FUSE_LSB    8
`define STAT_DLY_LSB     12
// Reset values
`define TRIM_RST         8'h80
// Clock source fuse codes
`define SRC_EXT          4'h0
`define SRC_MULT         4'h1
`define SRC_RC           4'h2
`define SRC_LEGACY       4'h3
`define SRC_LOW128       4'h4
`define SRC_RSV5         4'h5
`define SRC_LFXT         4'h6
`define SRC_RSV7         4'h7
// Decoded source codes
`define SEL_EXT          3'h0
`define SEL_MULT         3'h1
`define SEL_RC           3'h2
`define SEL_LEGACY       3'h3
`define SEL_LOW128       3'h4
`define SEL_LFXT         3'h5
`define SEL_XTAL         3'h6
`define SEL_RSV          3'h7
// Multiplier factors and system dividers
`define MULT_NORMAL      4'h8
`define MULT_LEGACY      4'h4
`define SYSDIV_ONE       3'h1
`define SYSDIV_FOUR      3'h4
// Start-up counts, source cycles
`define CNT_RESET_SRC    16'h000e
`define CNT_WAKE_SRC     16'h0006
`define CNT_MULT_WAKE_1K 16'h040e
`define CNT_MULT_WAKE_16K 16'h400e
// Start-up counts, watchdog oscillator cycles
`define CNT_WDT_4MS      16'h0200
`define CNT_WDT_64MS     16'h2000
`define CNT_NONE         16'h0000
`endif

// ---- logic/clock_source_select.v ----
// Clock source decode, start-up delay sequencing, multiplier control and
// clock domain gating, with an AHB-Lite register slave.
// Assumes fuses, wake, lock and oscillator ticks arrive asynchronously.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "clock_select_regs.vh"
module clock_source_select #(
  parameter SYNC_W = 10
) (
  // Clock and reset
  input  wire        core_clk_in,
  input  wire        rstn_in,
  // AHB-Lite slave
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [31:0] hrdata_out,
  // Fuses and asynchronous pins
  input  wire [3:0]  clock_source_fuses_in,
  input  wire [1:0]  startup_time_fuses_in,
  input  wire        wake_in,
  input  wire        multiplier_locked_in,
  input  wire        src_tick_in,
  input  wire        wdt_tick_in,
  // Sleep mode requests from the core
  input  wire        sleep_idle_in,
  input  wire        sleep_adc_nr_in,
  input  wire        sleep_power_down_in,
  input  wire        sleep_standby_in,
  // Clock controls
  output reg  [2:0]  clk_src_sel_out,
  output reg         legacy_mode_out,
  output reg         rc_osc_en_out,
  output reg         multiplier_run_out,
  output reg  [3:0]  multiplier_factor_out,
  output reg         multiplier_src_halve_out,
  output reg  [2:0]  sys_clk_div_out,
  output reg  [7:0]  oscillator_trim_out,
  // Domain gates
  output reg         core_clk_en_out,
  output reg         flash_clk_en_out,
  output reg         io_clk_en_out,
  output reg         adc_clk_en_out,
  output reg         async_int_detect_out,
  output reg         cpu_run_out
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  wire [SYNC_W-1:0] raw_in;
  reg  [SYNC_W-1:0] s1_ff;
  reg  [SYNC_W-1:0] s2_ff;
  reg  [SYNC_W-1:0] s3_ff;
  reg  [SYNC_W-1:0] filt_ff;

  assign raw_in = {wdt_tick_in, src_tick_in, multiplier_locked_in,
                   wake_in, startup_time_fuses_in, clock_source_fuses_in};

  // A change only counts once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1)
    begin : g_sync
      always @(posedge core_clk_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          s1_ff[gi]   <= 1'b1;
          s2_ff[gi]   <= 1'b1;
          s3_ff[gi]   <= 1'b1;
          filt_ff[gi] <= 1'b1;
        end
        else
        begin
          s1_ff[gi] <= raw_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi])
            filt_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate

  wire [3:0] src_code = filt_ff[3:0];
  wire [1:0] dly_code = filt_ff[5:4];
  wire       wake     = filt_ff[6];
  wire       locked   = filt_ff[7];
  wire       src_lvl  = filt_ff[8];
  wire       wdt_lvl  = filt_ff[9];

  // Rising edges of the oscillator ticks
  reg src_prev_ff;
  reg wdt_prev_ff;
  wire src_tick = src_lvl & ~src_prev_ff;
  wire wdt_tick = wdt_lvl & ~wdt_prev_ff;

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      src_prev_ff <= 1'b1;
      wdt_prev_ff <= 1'b1;
    end
    else
    begin
      src_prev_ff <= src_lvl;
      wdt_prev_ff <= wdt_lvl;
    end
  end

  // ==========================================================
  // Fuse decode
  // ==========================================================
  reg [2:0] sel;
  always @*
  begin
    // Codes compare raw bits: one reads unprogrammed
    case (src_code)
      `SRC_EXT:    sel = `SEL_EXT;
      `SRC_MULT:   sel = `SEL_MULT;
      `SRC_RC:     sel = `SEL_RC;
      `SRC_LEGACY: sel = `SEL_LEGACY;
      `SRC_LOW128: sel = `SEL_LOW128;
      `SRC_LFXT:   sel = `SEL_LFXT;
      `SRC_RSV5:   sel = `SEL_RSV;
      `SRC_RSV7:   sel = `SEL_RSV;
      default:     sel = `SEL_XTAL;
    endcase
  end

  wire mult_sys = (src_code == `SRC_MULT);
  wire legacy   = (src_code == `SRC_LEGACY);

  // ==========================================================
  // Registers over AHB-Lite
  // ==========================================================
  reg        enable_ff;
  reg        lss_ff;
  reg        lock_ff;
  reg  [7:0] trim_ff;
  reg        wr_pend_ff;
  reg  [7:0] wr_addr_ff;
  reg  [7:0] status_st;

  wire take = hsel_in & htrans_in[1] & hready_in;
  wire [7:0] a_ofs = {haddr_in[7:2], 2'b00};

  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      enable_ff  <= 1'b0;
      lss_ff     <= 1'b0;
      trim_ff    <= `TRIM_RST;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_out <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= take & hwrite_in;
      wr_addr_ff <= a_ofs;
      if (wr_pend_ff && wr_addr_ff == `REG_CTRL_OFS)
      begin
        enable_ff <= hwdata_in[`CTRL_ENABLE_BIT];
        // Refused while the multiplier drives the system clock
        lss_ff <= hwdata_in[`CTRL_LSS_BIT] & ~mult_sys;
      end
      else if (mult_sys)
        lss_ff <= 1'b0;
      // Trim only forwarded; keeping it low is software's job
      if (wr_pend_ff && wr_addr_ff == `REG_TRIM_OFS)
        trim_ff <= hwdata_in[7:0];
      if (take && !hwrite_in)
      begin
        case (a_ofs)
          `REG_CTRL_OFS:
            hrdata_out <= {29'h0, lss_ff, enable_ff, lock_ff};
          `REG_STATUS_OFS:
            hrdata_out <= {18'h0, dly_code, src_code, 2'b00, status_st[5:0]};
          `REG_TRIM_OFS:
            hrdata_out <= {24'h0, trim_ff};
          default:
            hrdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Start-up sequencer
  // ==========================================================
  localparam [5:0] ST_RST_SRC  = 6'b000001;
  localparam [5:0] ST_RST_WDT  = 6'b000010;
  localparam [5:0] ST_RUN      = 6'b000100;
  localparam [5:0] ST_SLEEP    = 6'b001000;
  localparam [5:0] ST_WAKE_SRC = 6'b010000;
  localparam [5:0] ST_WAKE_WDT = 6'b100000;

  reg  [5:0]  state_ff;
  reg  [5:0]  nxt_state;
  reg  [15:0] cnt_ff;
  reg  [15:0] nxt_cnt;
  reg  [15:0] rst_wdt_cnt;
  reg  [15:0] wake_src_cnt;
  reg  [15:0] wake_wdt_cnt;

  wire deep_sleep = sleep_power_down_in | sleep_standby_in;

  always @*
  begin
    if (mult_sys)
    begin
      // Power-on part is 4 ms in every case
      rst_wdt_cnt  = `CNT_WDT_4MS;
      wake_src_cnt = dly_code[0] ? `CNT_MULT_WAKE_16K : `CNT_MULT_WAKE_1K;
      wake_wdt_cnt = dly_code[1] ? `CNT_WDT_64MS : `CNT_WDT_4MS;
    end
    else
    begin
      // Reserved start-up code treated like the shortest
      case (dly_code)
        2'b01:   rst_wdt_cnt = `CNT_WDT_4MS;
        2'b10:   rst_wdt_cnt = `CNT_WDT_64MS;
        default: rst_wdt_cnt = `CNT_NONE;
      endcase
      wake_src_cnt = `CNT_WAKE_SRC;
      wake_wdt_cnt = `CNT_NONE;
    end
  end

  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_RST_SRC:
        if (src_tick)
        begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (nxt_cnt >= `CNT_RESET_SRC)
          begin
            nxt_cnt   = 16'h0000;
            nxt_state = (rst_wdt_cnt == `CNT_NONE) ? ST_RUN
                                                   : ST_RST_WDT;
          end
        end
      ST_RST_WDT:
        // Counted on the watchdog oscillator
        if (wdt_tick)
        begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (nxt_cnt >= rst_wdt_cnt)
          begin
            nxt_cnt   = 16'h0000;
            nxt_state = ST_RUN;
          end
        end
      ST_RUN:
        if (deep_sleep)
          nxt_state = ST_SLEEP;
      ST_SLEEP:
        if (wake || !deep_sleep)
        begin
          nxt_cnt   = 16'h0000;
          nxt_state = ST_WAKE_SRC;
        end
      ST_WAKE_SRC:
        // Selected source times the wake-up
        if (src_tick)
        begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (nxt_cnt >= wake_src_cnt)
          begin
            nxt_cnt   = 16'h0000;
            nxt_state = (wake_wdt_cnt == `CNT_NONE) ? ST_RUN
                                                    : ST_WAKE_WDT;
          end
        end
      ST_WAKE_WDT:
        if (wdt_tick)
        begin
          nxt_cnt = cnt_ff + 16'h0001;
          if (nxt_cnt >= wake_wdt_cnt)
          begin
            nxt_cnt   = 16'h0000;
            nxt_state = ST_RUN;
          end
        end
      default:
      begin
        nxt_cnt   = 16'h0000;
        nxt_state = ST_RST_SRC;
      end
    endcase
  end

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff <= ST_RST_SRC;
      cnt_ff   <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ==========================================================
  // Multiplier, lock and domain gating
  // ==========================================================
  wire running = (state_ff == ST_RUN);
  wire asleep  = (state_ff == ST_SLEEP);
  // Oscillator must run through the wake count itself
  wire osc_off = asleep;
  wire mult_on = (enable_ff | mult_sys | legacy) & ~osc_off;

  always @*
  begin
    status_st = {2'b00, mult_on, running, legacy, 3'b000};
    status_st[2:0] = sel;
  end

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      lock_ff                  <= 1'b0;
      clk_src_sel_out          <= `SEL_EXT;
      legacy_mode_out          <= 1'b0;
      rc_osc_en_out            <= 1'b0;
      multiplier_run_out       <= 1'b0;
      multiplier_factor_out    <= `MULT_NORMAL;
      multiplier_src_halve_out <= 1'b0;
      sys_clk_div_out          <= `SYSDIV_ONE;
      oscillator_trim_out      <= `TRIM_RST;
      core_clk_en_out          <= 1'b0;
      flash_clk_en_out         <= 1'b0;
      io_clk_en_out            <= 1'b0;
      adc_clk_en_out           <= 1'b0;
      async_int_detect_out     <= 1'b1;
      cpu_run_out              <= 1'b0;
    end
    else
    begin
      lock_ff <= mult_on & locked;
      clk_src_sel_out <= sel;
      legacy_mode_out <= legacy;
      rc_osc_en_out <= ~osc_off;
      multiplier_run_out <= mult_on;
      multiplier_factor_out <= legacy ? `MULT_LEGACY
                                      : `MULT_NORMAL;
      multiplier_src_halve_out <= lss_ff & ~legacy;
      sys_clk_div_out <= (mult_sys | legacy) ? `SYSDIV_FOUR
                                             : `SYSDIV_ONE;
      oscillator_trim_out <= trim_ff;
      // Core and flash gate together
      core_clk_en_out <= running & ~sleep_idle_in & ~sleep_adc_nr_in;
      flash_clk_en_out <= running & ~sleep_idle_in & ~sleep_adc_nr_in;
      io_clk_en_out <= running & ~sleep_adc_nr_in;
      // Converter keeps its clock in its noise-reduction sleep
      adc_clk_en_out <= running;
      // Asynchronous detect covers the halted I/O clock
      async_int_detect_out <= ~running | sleep_adc_nr_in;
      cpu_run_out <= running & ~sleep_idle_in & ~sleep_adc_nr_in;
    end
  end

endmodule

// ---- testbench/clk_sel_assertions.sv ----
// Checker for the clock select block outputs.
// Assumes binding onto clock_source_select.
`timescale 1ns/1ps
module clk_sel_checker (
  input wire       core_clk_in,
  input wire       rstn_in,
  input wire       sleep_power_down_in,
  input wire [2:0] clk_src_sel_out,
  input wire       legacy_mode_out,
  input wire       rc_osc_en_out,
  input wire       multiplier_run_out,
  input wire [3:0] multiplier_factor_out,
  input wire       multiplier_src_halve_out,
  input wire [2:0] sys_clk_div_out,
  input wire       core_clk_en_out,
  input wire       flash_clk_en_out,
  input wire       io_clk_en_out,
  input wire       async_int_detect_out,
  input wire       cpu_run_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // ==========
  // Output relations
  a_legacy_factor:
    assert property (legacy_mode_out |-> multiplier_factor_out == 4'h4)
    else $error("legacy factor wrong");
  a_normal_factor:
    assert property (!legacy_mode_out |-> multiplier_factor_out == 4'h8)
    else $error("normal factor wrong");
  a_legacy_halve:
    assert property (legacy_mode_out |-> !multiplier_src_halve_out)
    else $error("halving in legacy mode");
  a_mult_halve:
    assert property (clk_src_sel_out == 3'h1 |-> !multiplier_src_halve_out)
    else $error("halving with multiplier source");
  a_sys_div:
    assert property (sys_clk_div_out == ((clk_src_sel_out == 3'h1 ||
      clk_src_sel_out == 3'h3) ? 3'h4 : 3'h1))
    else $error("system divider wrong");
  a_flash_core:
    assert property (flash_clk_en_out == core_clk_en_out)
    else $error("flash gate differs from core gate");
  a_sleep_off:
    assert property (cpu_run_out && sleep_power_down_in |->
      ##2 (!rc_osc_en_out && !multiplier_run_out))
    else $error("oscillators still on in sleep");
  a_core_needs_run:
    assert property ($rose(core_clk_en_out) |-> cpu_run_out)
    else $error("core clock without run");
  a_async_detect:
    assert property (!io_clk_en_out |-> async_int_detect_out)
    else $error("async detect off while halted");
  a_fuse_mult_run:
    assert property (cpu_run_out && clk_src_sel_out == 3'h1 |->
      multiplier_run_out)
    else $error("multiplier off with fuse code");
  cover property ($rose(cpu_run_out));
  cover property (legacy_mode_out && multiplier_run_out);
  cover property ($fell(rc_osc_en_out));
endmodule
bind clock_source_select clk_sel_checker clk_sel_checker_inst (
  .core_clk_in              (core_clk_in),
  .rstn_in                  (rstn_in),
  .sleep_power_down_in      (sleep_power_down_in),
  .clk_src_sel_out          (clk_src_sel_out),
  .legacy_mode_out          (legacy_mode_out),
  .rc_osc_en_out            (rc_osc_en_out),
  .multiplier_run_out       (multiplier_run_out),
  .multiplier_factor_out    (multiplier_factor_out),
  .multiplier_src_halve_out (multiplier_src_halve_out),
  .sys_clk_div_out          (sys_clk_div_out),
  .core_clk_en_out          (core_clk_en_out),
  .flash_clk_en_out         (flash_clk_en_out),
  .io_clk_en_out            (io_clk_en_out),
  .async_int_detect_out     (async_int_detect_out),
  .cpu_run_out              (cpu_run_out)
);

// ---- testbench/clk_fuse_partner.sv ----
// Far side: fuse pins, source and watchdog oscillator ticks, lock pin.
// Assumes the bench changes fuses only while reset is held.
`timescale 1ns/1ps
module clk_fuse_partner (
  input  wire       core_clk_in,
  input  wire [3:0] fuse_code_in,
  input  wire [1:0] dly_code_in,
  input  wire       lock_in,
  output wire [3:0] fuses_out,
  output wire [1:0] dly_out,
  output reg        src_tick_out = 1'b0,
  output reg        wdt_tick_out = 1'b0,
  output wire       locked_out
);
  reg [1:0] div_ff = 2'h0;
  // Raw levels: 1 unprogrammed, 0 programmed
  assign fuses_out = fuse_code_in;
  assign dly_out = dly_code_in;
  assign locked_out = lock_in;
  // Fixed rate ticks, never stepping, period eight core clocks
  always @(posedge core_clk_in)
  begin
    div_ff <= div_ff + 2'h1;
    if (div_ff == 2'h3)
      src_tick_out <= ~src_tick_out;
    if (div_ff == 2'h1)
      wdt_tick_out <= ~wdt_tick_out;
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for clock_source_select.
// Assumes clk_fuse_partner drives fuses, ticks and lock.
`timescale 1ns/1ps
module testbench;
  logic        core_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0]  htrans_in = 2'h0;
  logic        hwrite_in = 1'b0;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic        wake_in = 1'b0;
  logic        sleep_idle_in = 1'b0;
  logic        sleep_adc_nr_in = 1'b0;
  logic        sleep_power_down_in = 1'b0;
  logic        sleep_standby_in = 1'b0;
  logic [3:0]  fuse_code = 4'h2;
  logic [1:0]  dly_code = 2'h0;
  logic        lock_pin = 1'b0;
  logic [31:0] rd;
  wire         hready_in, hreadyout_out, hresp_out;
  wire  [31:0] hrdata_out;
  wire  [3:0]  clock_source_fuses_in, multiplier_factor_out;
  wire  [1:0]  startup_time_fuses_in;
  wire         multiplier_locked_in, src_tick_in, wdt_tick_in;
  wire  [2:0]  clk_src_sel_out, sys_clk_div_out;
  wire         legacy_mode_out, rc_osc_en_out, multiplier_run_out;
  wire         multiplier_src_halve_out, core_clk_en_out;
  wire  [7:0]  oscillator_trim_out;
  wire         flash_clk_en_out, io_clk_en_out, adc_clk_en_out;
  wire         async_int_detect_out, cpu_run_out;
  int          err_count = 0;
  int          total_checks = 0;
  assign hready_in = hreadyout_out;
  always #2 core_clk_in = ~core_clk_in;
  clock_source_select clock_source_select_inst (
    .core_clk_in              (core_clk_in),
    .rstn_in                  (rstn_in),
    .hsel_in                  (hsel_in),
    .haddr_in                 (haddr_in),
    .htrans_in                (htrans_in),
    .hwrite_in                (hwrite_in),
    .hsize_in                 (hsize_in),
    .hwdata_in                (hwdata_in),
    .hready_in                (hready_in),
    .hreadyout_out            (hreadyout_out),
    .hresp_out                (hresp_out),
    .hrdata_out               (hrdata_out),
    .clock_source_fuses_in    (clock_source_fuses_in),
    .startup_time_fuses_in    (startup_time_fuses_in),
    .wake_in                  (wake_in),
    .multiplier_locked_in     (multiplier_locked_in),
    .src_tick_in              (src_tick_in),
    .wdt_tick_in              (wdt_tick_in),
    .sleep_idle_in            (sleep_idle_in),
    .sleep_adc_nr_in          (sleep_adc_nr_in),
    .sleep_power_down_in      (sleep_power_down_in),
    .sleep_standby_in         (sleep_standby_in),
    .clk_src_sel_out          (clk_src_sel_out),
    .legacy_mode_out          (legacy_mode_out),
    .rc_osc_en_out            (rc_osc_en_out),
    .multiplier_run_out       (multiplier_run_out),
    .multiplier_factor_out    (multiplier_factor_out),
    .multiplier_src_halve_out (multiplier_src_halve_out),
    .sys_clk_div_out          (sys_clk_div_out),
    .oscillator_trim_out      (oscillator_trim_out),
    .core_clk_en_out          (core_clk_en_out),
    .flash_clk_en_out         (flash_clk_en_out),
    .io_clk_en_out            (io_clk_en_out),
    .adc_clk_en_out           (adc_clk_en_out),
    .async_int_detect_out     (async_int_detect_out),
    .cpu_run_out              (cpu_run_out)
  );
  clk_fuse_partner clk_fuse_partner_inst (
    .core_clk_in  (core_clk_in),
    .fuse_code_in (fuse_code),
    .dly_code_in  (dly_code),
    .lock_in      (lock_pin),
    .fuses_out    (clock_source_fuses_in),
    .dly_out      (startup_time_fuses_in),
    .src_tick_out (src_tick_in),
    .wdt_tick_out (wdt_tick_in),
    .locked_out   (multiplier_locked_in)
  );
  // ==========
  // Checking and bus tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= a;
    hwrite_in <= w;
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge core_clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
    chk1(hresp_out, 1'b0);
  endtask
  // Counts watchdog and source rises until the core runs
  task automatic boot(input logic [3:0] c, input logic [1:0] s,
                      output int nw, output int ns);
    int k;
    logic pw, ps;
    rstn_in <= 1'b0;
    fuse_code <= c;
    dly_code <= s;
    repeat (4) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    nw = 0;
    ns = 0;
    pw = 1'b1;
    ps = 1'b1;
    for (k = 0; k < 6000 && cpu_run_out !== 1'b1; k++)
    begin
      @(posedge core_clk_in);
      nw += (wdt_tick_in && !pw);
      ns += (src_tick_in && !ps);
      pw = wdt_tick_in;
      ps = src_tick_in;
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_decode;
    logic [3:0] cd [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8,
                           4'hf, 4'h5};
    logic [2:0] sl [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
                           3'h6, 3'h7};
    int i, nw, ns;
    logic m, lg;
    for (i = 0; i < 9; i++)
    begin
      boot(cd[i], 2'h0, nw, ns);
      lg = cd[i] == 4'h3;
      m = cd[i] == 4'h1 || lg;
      bus(1'b0, 32'h4, 32'h0);
      chk32(rd & 32'h3f2f,
            {20'h0, cd[i], 2'h0, m, 1'b0, lg, sl[i]});
      chk32({29'h0, clk_src_sel_out}, {29'h0, sl[i]});
      chk1(legacy_mode_out, lg);
      chk32({28'h0, multiplier_factor_out}, lg ? 32'h4 : 32'h8);
      chk32({29'h0, sys_clk_div_out}, m ? 32'h4 : 32'h1);
      chk1(multiplier_run_out, m);
      if (i < 8)
        chk1(cpu_run_out, 1'b1);
      if (i == 2)
        chk1(ns >= 14 && ns <= 17, 1'b1);
    end
    $display("decode test done");
  endtask
  task automatic t_delay;
    int a, b, ns;
    boot(4'h2, 2'h0, a, ns);
    boot(4'h2, 2'h1, b, ns);
    chk1(b - a >= 510 && b - a <= 514, 1'b1);
    boot(4'h1, 2'h0, b, ns);
    chk1(b - a >= 510 && b - a <= 514, 1'b1);
    $display("delay test done");
  endtask
  task automatic t_regs;
    int nw, ns;
    boot(4'h2, 2'h0, nw, ns);
    bus(1'b0, 32'h8, 32'h0);
    chk32(rd, 32'h80);
    bus(1'b1, 32'h8, 32'h5a);
    bus(1'b1, 32'hc, 32'hffffffff);
    bus(1'b0, 32'hc, 32'h0);
    chk32(rd, 32'h0);
    chk32({24'h0, oscillator_trim_out}, 32'h5a);
    bus(1'b1, 32'h0, 32'h6);
    lock_pin <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    bus(1'b0, 32'h0, 32'h0);
    chk32(rd & 32'h7, 32'h7);
    chk1(multiplier_run_out, 1'b1);
    chk1(multiplier_src_halve_out, 1'b1);
    lock_pin <= 1'b0;
    boot(4'h1, 2'h0, nw, ns);
    bus(1'b1, 32'h0, 32'h4);
    bus(1'b0, 32'h0, 32'h0);
    chk32(rd & 32'h4, 32'h0);
    boot(4'h3, 2'h0, nw, ns);
    bus(1'b1, 32'h0, 32'h4);
    bus(1'b0, 32'h0, 32'h0);
    chk1(multiplier_src_halve_out, 1'b0);
    $display("register test done");
  endtask
  task automatic t_sleep;
    int nw, ns, k, m;
    logic ps;
    boot(4'h3, 2'h0, nw, ns);
    sleep_idle_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk1(core_clk_en_out, 1'b0);
    chk1(io_clk_en_out, 1'b1);
    chk1(flash_clk_en_out, 1'b0);
    sleep_idle_in <= 1'b0;
    sleep_adc_nr_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    chk1(io_clk_en_out, 1'b0);
    chk1(adc_clk_en_out, 1'b1);
    chk1(async_int_detect_out, 1'b1);
    sleep_adc_nr_in <= 1'b0;
    for (m = 0; m < 2; m++)
    begin
      repeat (3) @(posedge core_clk_in);
      sleep_power_down_in <= (m == 0);
      sleep_standby_in <= (m == 1);
      // Rises from here already reach the wake count via the synchroniser
      ns = 0;
      ps = src_tick_in;
      for (k = 0; k < 3; k++)
      begin
        @(posedge core_clk_in);
        ns += (src_tick_in && !ps);
        ps = src_tick_in;
      end
      chk1(rc_osc_en_out, 1'b0);
      chk1(multiplier_run_out, 1'b0);
      chk1(cpu_run_out, 1'b0);
      sleep_power_down_in <= 1'b0;
      sleep_standby_in <= 1'b0;
      wake_in <= 1'b1;
      for (k = 0; k < 500 && cpu_run_out !== 1'b1; k++)
      begin
        @(posedge core_clk_in);
        ns += (src_tick_in && !ps);
        ps = src_tick_in;
      end
      wake_in <= 1'b0;
      chk1(ns >= 6 && ns <= 8, 1'b1);
    end
    $display("sleep test done");
  endtask
  initial
  begin
    t_decode;
    t_delay;
    t_regs;
    t_sleep;
    end_sim;
  end
  initial
  begin
    #200000;
    err_count++;
    end_sim;
  end
endmodule
